// ### pkg/dfs_pkg.sv
package dfs_pkg;

  localparam int          CLK_HZ       = 20_000_000;
  localparam int          TICK_S       = 1;
  localparam int          DEB_MS       = 20;
  localparam int          SEC_CYC_DEF  = CLK_HZ * TICK_S;
  localparam int          DEB_CYC_DEF  = CLK_HZ / 1000 * DEB_MS;

  // ui timeouts in seconds
  localparam logic [2:0]  HOLD_S       = 3'h7;
  localparam logic [2:0]  WINDOW_S     = 3'h5;
  localparam logic [2:0]  STORE_S      = 3'h2;

  // density index 0..12 stands for 0.60..1.20 in 0.05 steps
  localparam int          DEN_W        = 4;
  localparam logic [3:0]  DEN_MAX_IDX  = 4'hc;
  localparam logic [3:0]  DEN_DEF_IDX  = 4'h6;
  localparam logic [6:0]  DEN_BASE_HUN = 7'h3c;
  localparam logic [6:0]  DEN_STEP_HUN = 7'h05;

  // avalon byte offsets and register field bit positions
  localparam logic [3:0]  REG_STATUS   = 4'h0;
  localparam logic [3:0]  REG_CONFIG   = 4'h4;
  localparam logic [3:0]  REG_LEVEL    = 4'h8;
  localparam int          FLD_DEN_LSB  = 0;
  localparam int          FLD_FLT_BIT  = 8;
  localparam int          FLD_ST_LSB   = 16;
  localparam int          FLD_VLD_BIT  = 24;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_HOLD, ST_SHOW_DEN, ST_SHOW_FLT, ST_DEN_WAIT, ST_FLT_WAIT, ST_STORE
  } dfs_st_t;

  typedef enum logic [2:0] {
    DISP_LEVEL, DISP_DEN_CUR, DISP_DEN_PROG, DISP_FLOAT, DISP_STORE
  } dfs_disp_t;

  function automatic logic [6:0] dfs_den_hun(input logic [3:0] idx);
    return DEN_BASE_HUN + DEN_STEP_HUN * {3'h0, idx};
  endfunction

  // true in the last second of a t-second wait
  function automatic logic dfs_due(input logic [2:0] sec, input logic [2:0] t);
    return sec == t - 3'h1;
  endfunction

endpackage

// ### verilog/dfs_debounce.sv
`timescale 1ns/1ps
module dfs_debounce #(
  parameter int DEB_CYC = dfs_pkg::DEB_CYC_DEF
)(
  input  wire logic clk,      // system clock
  input  wire logic srst,     // sync reset
  input  wire logic pin,      // raw button, high = pressed
  output logic      level     // debounced pressed level
);
  import dfs_pkg::*;

  localparam int CW = $clog2(DEB_CYC + 1);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          stable;
    logic [CW-1:0] cnt;
  } dfs_deb_t;

  dfs_deb_t s_r;
  dfs_deb_t s_nxt;

  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.s1 = pin;
    s_nxt.s2 = s_r.s1;
    if (s_r.s2 != s_r.stable)
    begin
      s_nxt.cnt = s_r.cnt + CW'(1);
      if (s_r.cnt == CW'(DEB_CYC - 1))
      begin
        s_nxt.stable = s_r.s2;
        s_nxt.cnt    = '0;
      end
    end
    else
      s_nxt.cnt = '0;
  end

  always_ff @(posedge clk)
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;

  assign level = s_r.stable;

  deb_settle_a: assert property (@(posedge clk) disable iff (srst)
    $changed(s_r.stable) |-> $past(s_r.s2 != s_r.stable))
    else $error("debounced level moved without a differing input");

endmodule // dfs_debounce

// ### verilog/dfs_corr_lut.sv
`timescale 1ns/1ps
module dfs_corr_lut (
  input  wire logic              clk,     // system clock
  input  wire logic              srst,    // sync reset
  input  wire logic [3:0]        den_idx, // density index
  input  wire logic              steel,   // 1 = steel float
  input  wire logic              sixth,   // 1 = sixth-inch steps
  output logic signed [3:0]      corr     // correction in level steps
);
  import dfs_pkg::*;

  typedef struct packed {
    logic signed [3:0] corr;
  } dfs_lut_t;

  dfs_lut_t s_r;
  dfs_lut_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    case ({steel, sixth})
      2'b00:   case (den_idx) inside
                 4'h0:          s_nxt.corr = 4'sh2;
                 [4'h1:4'h3]:   s_nxt.corr = 4'sh1;
                 [4'hb:4'hc]:   s_nxt.corr = -4'sh1;
                 default:       s_nxt.corr = 4'sh0;
               endcase
      2'b01:   case (den_idx) inside
                 4'h0:          s_nxt.corr = 4'sh4;
                 4'h1:          s_nxt.corr = 4'sh3;
                 [4'h2:4'h3]:   s_nxt.corr = 4'sh2;
                 4'h4:          s_nxt.corr = 4'sh1;
                 [4'h9:4'ha]:   s_nxt.corr = -4'sh1;
                 [4'hb:4'hc]:   s_nxt.corr = -4'sh2;
                 default:       s_nxt.corr = 4'sh0;
               endcase
      2'b10:   case (den_idx) inside
                 4'h0:          s_nxt.corr = 4'sh3;
                 [4'h1:4'h2]:   s_nxt.corr = 4'sh2;
                 4'h3:          s_nxt.corr = 4'sh1;
                 [4'h9:4'hc]:   s_nxt.corr = -4'sh1;
                 default:       s_nxt.corr = 4'sh0;
               endcase
      default: case (den_idx) inside
                 4'h0:          s_nxt.corr = 4'sh6;
                 4'h1:          s_nxt.corr = 4'sh4;
                 4'h2:          s_nxt.corr = 4'sh3;
                 4'h3:          s_nxt.corr = 4'sh2;
                 4'h4:          s_nxt.corr = 4'sh1;
                 4'h8:          s_nxt.corr = -4'sh1;
                 [4'h9:4'hb]:   s_nxt.corr = -4'sh2;
                 4'hc:          s_nxt.corr = -4'sh3;
                 default:       s_nxt.corr = 4'sh0;
               endcase
    endcase
  end

  always_ff @(posedge clk)
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;

  assign corr = s_r.corr;

  lut_ends_a: assert property (@(posedge clk) disable iff (srst)
    steel && sixth && (den_idx == 4'h0 || den_idx == 4'hc)
    |=> corr == (($past(den_idx) == 4'h0) ? 4'sh6 : -4'sh3))
    else $error("steel sixth-inch table ends wrong");

endmodule // dfs_corr_lut

// ### verilog/dfs_setting_ui.sv
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
// How it works
// - density powers up at 0.90, which gives zero correction for both floats.
// - plastic third-inch: +2, +1, 0, -1 steps across 0.60..1.20.
// - plastic sixth-inch: +4, +3, +2, +1, 0, -1, -2 steps across densities.
// - steel third-inch: +3, +2, +1, 0, -1 steps across densities.
// - steel sixth-inch: +6 down to -3 steps across densities.
// - the selected correction is added to the displayed level.
// - raw inch jumper or programming activity bypasses the correction.
// - setting entry needs a valid level reading.
// - down held seven seconds shows current density; operator then releases.
// - no press for five seconds returns to normal, density unchanged.
// - each down press shows program prefix, adds 0.05, wraps 1.20 to 0.60.
// - five idle seconds after a change stores density, shows store two seconds.
// - shutdown press while density shown and down still held opens the float view.
// - each shutdown press in the window toggles float; else exit unchanged.
// - store shown two seconds after float view only if float changed.
// - stored float type picks the correction table.
module dfs_setting_ui #(
  parameter int SEC_CYC = dfs_pkg::SEC_CYC_DEF,  // clocks per second
  parameter int DEB_CYC = dfs_pkg::DEB_CYC_DEF   // button settle clocks
)(
  input  wire logic             clk,             // 20 MHz clock
  input  wire logic             srst,            // sync reset, high
  input  wire logic             btn_down_pin,    // down button pin, high = pressed
  input  wire logic             btn_shut_pin,    // shutdown button pin
  input  wire logic             raw_inch_pin,    // raw inch jumper pin
  input  wire logic             prog_active,     // programming or copying underway
  input  wire logic             sixth_mode,      // 1 = sixth-inch steps
  input  wire logic             level_valid,     // level reading is good
  input  wire logic [15:0]      level_raw,       // level in steps
  input  wire logic [3:0]       avs_address,     // byte address
  input  wire logic             avs_read,        // read strobe
  input  wire logic             avs_write,       // write strobe
  input  wire logic [31:0]      avs_writedata,   // write data
  output logic [31:0]           avs_readdata,    // read data
  output logic                  avs_waitrequest, // stall
  output dfs_pkg::dfs_disp_t    disp_sel,        // what the display shows
  output logic [6:0]            disp_den_hun,    // density in hundredths
  output logic                  disp_float_steel,// float shown, 1 = steel
  output logic [15:0]           disp_level,      // corrected level
  output logic                  nv_save          // pulse: save settings
);
  import dfs_pkg::*;

  localparam int TW = $clog2(SEC_CYC + 1);

  typedef struct packed {
    dfs_st_t           st;
    logic              jmp_s1;
    logic              jmp_s2;
    logic              dn_prev;
    logic              sh_prev;
    logic [TW-1:0]     tick_cnt;
    logic [2:0]        sec;
    logic [DEN_W-1:0]  den_store;
    logic [DEN_W-1:0]  den_work;
    logic              flt_store;
    logic              flt_work;
    logic              den_chg;
    logic              nv_save;
    dfs_disp_t         disp_sel;
    logic [6:0]        disp_den;
    logic              disp_flt;
    logic [15:0]       disp_level;
    logic              ack;
    logic [31:0]       rdata;
  } dfs_state_t;

  dfs_state_t        s_r;
  dfs_state_t        s_nxt;
  logic              dn_lvl;
  logic              sh_lvl;
  logic signed [3:0] corr;
  logic              dn_press;
  logic              sh_press;
  logic              tick;
  logic              bypass;
  logic signed [17:0] lvl_sum;

  dfs_debounce #(.DEB_CYC(DEB_CYC)) u_deb_dn (
    .clk   (clk),
    .srst  (srst),
    .pin   (btn_down_pin),
    .level (dn_lvl)
  );

  dfs_debounce #(.DEB_CYC(DEB_CYC)) u_deb_sh (
    .clk   (clk),
    .srst  (srst),
    .pin   (btn_shut_pin),
    .level (sh_lvl)
  );

  // corrections follow the stored settings, not the ones being edited
  dfs_corr_lut u_lut (
    .clk     (clk),
    .srst    (srst),
    .den_idx (s_r.den_store),
    .steel   (s_r.flt_store),
    .sixth   (sixth_mode),
    .corr    (corr)
  );

  // press = rising edge of the debounced level, so a held button counts once
  assign dn_press = dn_lvl & ~s_r.dn_prev;
  assign sh_press = sh_lvl & ~s_r.sh_prev;
  assign tick     = s_r.tick_cnt == TW'(SEC_CYC - 1);
  assign bypass   = s_r.jmp_s2 | prog_active;
  assign lvl_sum  = $signed({2'b00, level_raw}) + 18'(corr);

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.jmp_s1  = raw_inch_pin;
    s_nxt.jmp_s2  = s_r.jmp_s1;
    s_nxt.dn_prev = dn_lvl;
    s_nxt.sh_prev = sh_lvl;
    s_nxt.nv_save = 1'b0;

    // seconds base; restarted below whenever a wait begins anew
    if (tick)
    begin
      s_nxt.tick_cnt = '0;
      if (s_r.sec != 3'h7)
        s_nxt.sec = s_r.sec + 3'h1;
    end
    else
      s_nxt.tick_cnt = s_r.tick_cnt + TW'(1);

    case (s_r.st)
      ST_NORMAL:
        if (dn_lvl && level_valid)
        begin
          s_nxt.st       = ST_HOLD;
          s_nxt.tick_cnt = '0;
          s_nxt.sec      = '0;
        end
      ST_HOLD:
        if (!dn_lvl)
          s_nxt.st = ST_NORMAL;
        else if (tick && dfs_due(s_r.sec, HOLD_S))
        begin
          s_nxt.st       = ST_SHOW_DEN;
          s_nxt.den_work = s_r.den_store;
          s_nxt.flt_work = s_r.flt_store;
          s_nxt.den_chg  = 1'b0;
        end
      ST_SHOW_DEN:
        if (sh_lvl)
          s_nxt.st = ST_SHOW_FLT;
        else if (!dn_lvl)
        begin
          s_nxt.st       = ST_DEN_WAIT;
          s_nxt.tick_cnt = '0;
          s_nxt.sec      = '0;
        end
      ST_SHOW_FLT:
        if (!dn_lvl && !sh_lvl)
        begin
          s_nxt.st       = ST_FLT_WAIT;
          s_nxt.tick_cnt = '0;
          s_nxt.sec      = '0;
        end
      ST_DEN_WAIT:
        if (dn_press)
        begin
          s_nxt.den_chg  = 1'b1;
          s_nxt.den_work = (s_r.den_work == DEN_MAX_IDX) ? '0 : s_r.den_work + 4'h1;
          s_nxt.tick_cnt = '0;
          s_nxt.sec      = '0;
        end
        else if (tick && dfs_due(s_r.sec, WINDOW_S))
        begin
          if (s_r.den_chg)
          begin
            s_nxt.st        = ST_STORE;
            s_nxt.den_store = s_r.den_work;
            s_nxt.nv_save   = 1'b1;
            s_nxt.tick_cnt  = '0;
            s_nxt.sec       = '0;
          end
          else
            s_nxt.st = ST_NORMAL;
        end
      ST_FLT_WAIT:
        // any press restarts the window; only shutdown toggles the float
        if (sh_press || dn_press)
        begin
          if (sh_press)
            s_nxt.flt_work = ~s_r.flt_work;
          s_nxt.tick_cnt = '0;
          s_nxt.sec      = '0;
        end
        else if (tick && dfs_due(s_r.sec, WINDOW_S))
        begin
          if (s_r.flt_work != s_r.flt_store)
          begin
            s_nxt.st        = ST_STORE;
            s_nxt.flt_store = s_r.flt_work;
            s_nxt.nv_save   = 1'b1;
            s_nxt.tick_cnt  = '0;
            s_nxt.sec       = '0;
          end
          else
            s_nxt.st = ST_NORMAL;
        end
      ST_STORE:
        if (tick && dfs_due(s_r.sec, STORE_S))
          s_nxt.st = ST_NORMAL;
      default:
        s_nxt.st = ST_NORMAL;
    endcase

    case (s_r.st)
      ST_SHOW_DEN,
      ST_DEN_WAIT: s_nxt.disp_sel = s_nxt.den_chg ? DISP_DEN_PROG : DISP_DEN_CUR;
      ST_SHOW_FLT,
      ST_FLT_WAIT: s_nxt.disp_sel = DISP_FLOAT;
      ST_STORE:    s_nxt.disp_sel = DISP_STORE;
      default:     s_nxt.disp_sel = DISP_LEVEL;
    endcase
    s_nxt.disp_den = dfs_den_hun(s_nxt.den_work);
    s_nxt.disp_flt = s_nxt.flt_work;

    // clamp rather than wrap: a reading near empty must not jump to full scale
    if (bypass)
      s_nxt.disp_level = level_raw;
    else if (lvl_sum < 0)
      s_nxt.disp_level = '0;
    else if (lvl_sum > 18'sh0ffff)
      s_nxt.disp_level = 16'hffff;
    else
      s_nxt.disp_level = lvl_sum[15:0];

    // one wait state per access; a hardware store beats a same-cycle write
    s_nxt.ack = (avs_read | avs_write) & ~s_r.ack;
    if (avs_read && !s_r.ack)
    begin
      case (avs_address)
        REG_STATUS:
        begin
          s_nxt.rdata = '0;
          s_nxt.rdata[FLD_DEN_LSB +: DEN_W] = s_r.den_store;
          s_nxt.rdata[FLD_FLT_BIT]          = s_r.flt_store;
          s_nxt.rdata[FLD_ST_LSB +: 3]      = s_r.st;
          s_nxt.rdata[FLD_VLD_BIT]          = level_valid;
        end
        REG_CONFIG:
        begin
          s_nxt.rdata = '0;
          s_nxt.rdata[FLD_DEN_LSB +: DEN_W] = s_r.den_store;
          s_nxt.rdata[FLD_FLT_BIT]          = s_r.flt_store;
        end
        REG_LEVEL: s_nxt.rdata = {16'h0000, s_r.disp_level};
        default:   s_nxt.rdata = '0;
      endcase
    end
    if (avs_write && s_r.ack && avs_address == REG_CONFIG && !s_nxt.nv_save)
    begin
      if (avs_writedata[FLD_DEN_LSB +: DEN_W] <= DEN_MAX_IDX)
        s_nxt.den_store = avs_writedata[FLD_DEN_LSB +: DEN_W];
      s_nxt.flt_store = avs_writedata[FLD_FLT_BIT];
    end
  end

  always_ff @(posedge clk)
    if (srst)
    begin
      s_r           <= '0;
      s_r.st        <= ST_NORMAL;
      s_r.den_store <= DEN_DEF_IDX;
      s_r.den_work  <= DEN_DEF_IDX;
      s_r.disp_sel  <= DISP_LEVEL;
    end
    else
      s_r <= s_nxt;

  // stall is combinational; the master must hold its request through it
  assign avs_waitrequest  = (avs_read | avs_write) & ~s_r.ack;
  assign avs_readdata     = s_r.rdata;
  assign disp_sel         = s_r.disp_sel;
  assign disp_den_hun     = s_r.disp_den;
  assign disp_float_steel = s_r.disp_flt;
  assign disp_level       = s_r.disp_level;
  assign nv_save          = s_r.nv_save;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence wait_expires(dfs_st_t w);
    s_r.st == w && tick && dfs_due(s_r.sec, WINDOW_S);
  endsequence

  default_den_a: assert property ($past(srst) |->
    s_r.den_store == DEN_DEF_IDX ##2 (s_r.den_store != DEN_DEF_IDX || corr == 4'sh0))
    else $error("default density not 0.90 or not zero correction");
  entry_valid_a: assert property (
    s_r.st == ST_NORMAL && !level_valid |=> s_r.st != ST_HOLD)
    else $error("setting entered without a valid level");
  hold_show_a: assert property (
    s_r.st == ST_HOLD && dn_lvl && tick && dfs_due(s_r.sec, HOLD_S)
    |=> s_r.st == ST_SHOW_DEN ##1 s_r.disp_sel == DISP_DEN_CUR)
    else $error("density not shown after hold");
  den_step_a: assert property (
    s_r.st == ST_DEN_WAIT && dn_press
    |=> s_r.den_work == (($past(s_r.den_work) == DEN_MAX_IDX) ? 4'h0 : $past(s_r.den_work) + 4'h1)
    ##1 s_r.disp_sel == DISP_DEN_PROG)
    else $error("density step or wrap wrong");
  den_quiet_a: assert property (
    wait_expires(ST_DEN_WAIT) ##0 (!dn_press && !s_r.den_chg)
    |=> s_r.st == ST_NORMAL && $stable(s_r.den_store))
    else $error("density view did not close unchanged");
  den_store_a: assert property (
    wait_expires(ST_DEN_WAIT) ##0 (!dn_press && s_r.den_chg)
    |=> s_r.st == ST_STORE && nv_save && s_r.den_store == $past(s_r.den_work))
    else $error("changed density not stored");
  flt_toggle_a: assert property (
    s_r.st == ST_FLT_WAIT && sh_press |=> s_r.flt_work != $past(s_r.flt_work))
    else $error("float type did not toggle");
  flt_store_a: assert property (
    wait_expires(ST_FLT_WAIT) ##0 (!sh_press && !dn_press)
    |=> (s_r.st == ST_STORE) == ($past(s_r.flt_work) != $past(s_r.flt_store)))
    else $error("float store shown wrongly");
  bypass_lvl_a: assert property (
    bypass |=> disp_level == $past(level_raw))
    else $error("correction not bypassed");
  avs_once_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait");

  sequence shows(dfs_disp_t d);
    disp_sel == d;
  endsequence

  // entry decision is taken on the cycle before the hold state appears
  hold_entry_a: assert property (
    $rose(s_r.st == ST_HOLD) |-> $past(level_valid))
    else $error("hold started without a valid level");
  store_show_a: assert property (
    nv_save |-> s_r.st == ST_STORE ##1 shows(DISP_STORE))
    else $error("store not shown after a save");
  flt_show_a: assert property (
    s_r.st == ST_SHOW_DEN && sh_lvl |=> s_r.st == ST_SHOW_FLT ##1 shows(DISP_FLOAT))
    else $error("float view not opened");
  flt_restart_a: assert property (
    s_r.st == ST_FLT_WAIT && (sh_press || dn_press)
    |=> s_r.st == ST_FLT_WAIT && s_r.sec == 3'h0)
    else $error("float window not restarted by a press");
  lvl_floor_a: assert property (
    !bypass && lvl_sum < 0 |=> disp_level == 16'h0000)
    else $error("negative corrected level not clamped");

endmodule // dfs_setting_ui

// ### sim/dfs_operator.sv
`timescale 1ns/1ps
// finger on two buttons; slow mode makes the contacts chatter before settling
module dfs_operator (
  input  wire logic       clk,   // system clock
  input  wire logic [1:0] want,  // bit0 down, bit1 shutdown, 1 = finger on button
  input  wire logic       slow,  // chatter on every change
  output logic      [1:0] pin    // button pins, high = pressed
);
  logic [1:0]      prev = 2'h0;
  logic [1:0][2:0] chat = '0;

  initial pin = 2'h0;

  // the bench holds down until the density shows, then lets go
  // both buttons are let go once the float type shows
  always @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (want[i] !== prev[i])
      begin
        prev[i] <= want[i];
        chat[i] <= slow ? 3'h4 : 3'h0;
      end
      else if (chat[i] != 3'h0)
      begin
        // never stable long enough to pass as a press
        pin[i]  <= ~pin[i];
        chat[i] <= chat[i] - 3'h1;
      end
      else
        pin[i] <= prev[i];
    end
  end
endmodule // dfs_operator

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dfs_pkg::*;
  localparam int SEC = 20;
  logic        clk, srst, raw_inch_pin, prog_active, sixth_mode, level_valid, slow;
  logic [15:0] level_raw, disp_level, raw;
  logic [3:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, disp_float_steel, nv_save;
  logic [31:0] avs_writedata, avs_readdata;
  logic [6:0]  disp_den_hun;
  logic [1:0]  want, pins;
  dfs_disp_t   disp_sel;
  int          n_mismatch, check_count, nv_cnt, seed, e;
  logic [31:0] exp_q[$];
  // rows: plastic third, plastic sixth, steel third, steel sixth
  int tbl [4][13] = '{'{2, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, -1, -1},
                      '{4, 3, 2, 2, 1, 0, 0, 0, 0, -1, -1, -2, -2},
                      '{3, 2, 2, 1, 0, 0, 0, 0, 0, -1, -1, -1, -1},
                      '{6, 4, 3, 2, 1, 0, 0, 0, -1, -2, -2, -2, -3}};

  dfs_setting_ui #(.SEC_CYC(SEC), .DEB_CYC(3)) dut_u (
    .clk(clk), .srst(srst), .btn_down_pin(pins[0]), .btn_shut_pin(pins[1]),
    .raw_inch_pin(raw_inch_pin), .prog_active(prog_active), .sixth_mode(sixth_mode),
    .level_valid(level_valid), .level_raw(level_raw), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .disp_sel(disp_sel),
    .disp_den_hun(disp_den_hun), .disp_float_steel(disp_float_steel),
    .disp_level(disp_level), .nv_save(nv_save));

  dfs_operator op_u (.clk(clk), .want(want), .slow(slow), .pin(pins));

  function automatic logic [31:0] stat(input logic [3:0] i, input logic f,
                                       input logic [2:0] s, input logic v);
    return {7'h0, v, 5'h0, s, 7'h0, f, 4'h0, i};
  endfunction

  task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    cmp_v(got, exp);
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one Avalon transfer; holds everything until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 50)
      n_mismatch++;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  // cycles until the display shows s must fall in [lo, hi)
  task automatic span(input dfs_disp_t s, input int lo, input int hi);
    int n;
    n = 0;
    while (disp_sel !== s && n < hi)
    begin
      @(posedge clk);
      n++;
    end
    cmp_v(32'(n >= lo && n < hi), 32'h1);
  endtask

  task automatic press(input int b);
    want[b] <= 1'b1;
    repeat (10) @(posedge clk);
    want[b] <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  task automatic enter_view();
    want[0] <= 1'b1;
    span(DISP_DEN_CUR, 7 * SEC, 7 * SEC + 20);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // results appear when a read completes; the oldest note is compared
  always @(posedge clk)
  begin
    if (nv_save === 1'b1)
      nv_cnt++;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        n_mismatch++;
      else
        cmp_rd(avs_readdata, exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (12000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    {srst, raw_inch_pin, prog_active, sixth_mode, level_valid, slow} = 6'h22;
    {avs_read, avs_write, avs_address, avs_writedata, want} = '0;
    level_raw = 16'h0100;
    seed = 65;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    cmp_v(32'(disp_sel), 32'(DISP_LEVEL));
    cmp_v(32'(disp_den_hun), 32'h5a);
    cmp_v(32'(disp_level), 32'h100);
    rd(REG_STATUS, stat(4'h6, 1'b0, 3'h0, 1'b1));
    rd(4'hc, 32'h0);
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b1, REG_STATUS, 32'h0);
    bus(1'b1, REG_CONFIG, stat(4'hd, 1'b1, 3'h0, 1'b0));
    rd(REG_CONFIG, stat(4'h6, 1'b1, 3'h0, 1'b0));
    for (int m = 0; m < 4; m++)
      for (int d = 0; d < 13; d++)
      begin
        sixth_mode <= m[0];
        bus(1'b1, REG_CONFIG, stat(4'(d), m[1], 3'h0, 1'b0));
        raw = (d % 5 == 0) ? 16'h0 : 16'($random(seed));
        level_raw <= raw;
        repeat (4) @(posedge clk);
        e = int'(raw) + tbl[m][d];
        e = (e < 0) ? 0 : (e > 65535) ? 65535 : e;
        cmp_v(32'(disp_level), 32'(e));
      end
    raw_inch_pin <= 1'b1;
    repeat (6) @(posedge clk);
    cmp_v(32'(disp_level), 32'(raw));
    raw_inch_pin <= 1'b0;
    prog_active  <= 1'b1;
    repeat (4) @(posedge clk);
    cmp_v(32'(disp_level), 32'(raw));
    prog_active <= 1'b0;
    sixth_mode  <= 1'b0;
    level_raw   <= 16'h0200;
    bus(1'b1, REG_CONFIG, stat(4'h6, 1'b0, 3'h0, 1'b0));
    // density change through the wrap, then stored
    enter_view();
    cmp_v(32'(disp_den_hun), 32'h5a);
    want[0] <= 1'b0;
    repeat (10) @(posedge clk);
    for (int k = 1; k < 8; k++)
    begin
      press(0);
      cmp_v(32'(disp_sel), 32'(DISP_DEN_PROG));
      cmp_v(32'(disp_den_hun), 32'((k < 7) ? 90 + 5 * k : 60));
    end
    span(DISP_STORE, 5 * SEC - 24, 5 * SEC - 4);
    cmp_v(32'(nv_cnt), 32'h1);
    span(DISP_LEVEL, 2 * SEC - 3, 2 * SEC + 3);
    rd(REG_CONFIG, stat(4'h0, 1'b0, 3'h0, 1'b0));
    // float view with three toggles, stored as steel
    enter_view();
    want[1] <= 1'b1;
    span(DISP_FLOAT, 0, 15);
    cmp_v(32'(disp_float_steel), 32'h0);
    want <= 2'h0;
    repeat (10) @(posedge clk);
    for (int k = 1; k < 4; k++)
    begin
      press(1);
      cmp_v(32'(disp_float_steel), 32'(k % 2));
    end
    span(DISP_STORE, 5 * SEC - 24, 5 * SEC - 4);
    cmp_v(32'(nv_cnt), 32'h2);
    span(DISP_LEVEL, 2 * SEC - 3, 2 * SEC + 3);
    rd(REG_CONFIG, stat(4'h0, 1'b1, 3'h0, 1'b0));
    cmp_v(32'(disp_level), 32'h203);
    // float view left alone: no store
    enter_view();
    want[1] <= 1'b1;
    span(DISP_FLOAT, 0, 15);
    want <= 2'h0;
    span(DISP_LEVEL, 5 * SEC, 5 * SEC + 15);
    cmp_v(32'(nv_cnt), 32'h2);
    // density view only, with chattering contacts
    slow <= 1'b1;
    enter_view();
    cmp_v(32'(disp_den_hun), 32'h3c);
    want[0] <= 1'b0;
    span(DISP_LEVEL, 5 * SEC, 5 * SEC + 20);
    cmp_v(32'(nv_cnt), 32'h2);
    rd(REG_CONFIG, stat(4'h0, 1'b1, 3'h0, 1'b0));
    slow <= 1'b0;
    // no valid reading: the hold is refused
    level_valid <= 1'b0;
    want[0]     <= 1'b1;
    repeat (8 * SEC) @(posedge clk);
    cmp_v(32'(disp_sel), 32'(DISP_LEVEL));
    rd(REG_STATUS, stat(4'h0, 1'b1, 3'h0, 1'b0));
    want[0] <= 1'b0;
    repeat (4) @(posedge clk);
    cmp_v(32'(exp_q.size()), 32'h0);
    close_out();
  end
endmodule // testbench
